/* uec_pkg.sv */
// What this block does
// R01 - Config register at special address d4 acts on the selected endpoint
// R02 - Config bit 7 enables the selected endpoint when 1, disables when 0
// R03 - Firmware enables endpoint 0 after any hardware or bus reset
// R04 - Config bits 6 to 4 are reserved and read as zero
// R05 - Toggle status bit 3 set on DATA1 receipt, cleared on DATA0 receipt
// R06 - Firmware discards a bulk packet whose toggle did not change
// R07 - Expected toggle returns to DATA0 only when the endpoint is configured
// R08 - Interrupt endpoints toggle the same way as bulk endpoints
// R09 - Control setup starts with DATA0, then alternates as bulk
// R10 - Control read status stage completes with a DATA1 packet
// R11 - Firmware collects every isochronous packet, may ignore toggle status
// R12 - Config bit 2 selects IN when 1, OUT when 0, for non-control types
// R13 - Direction bit has no effect on control endpoints
// R14 - Type field bits 1 to 0; endpoint 0 must be configured as control
// R15 - Config register resets to all zeros
// R16 - Status bits: dir 7, stall 5, ready 4, flag 3, setup 2, out 1, done 0
// R17 - Type encoding: control 00, isochronous 01, bulk 10, interrupt 11
// R18 - Valid setup sets setup flag, clears other status bits
// R19 - While OUT flag set, further OUT packets are answered with NAK
// R20 - Transmit ready cleared when sent (iso) or acknowledged (other types)
// R21 - Stall request makes the endpoint answer the next handshake with STALL
package uec_pkg;

  // ****************************************
  // Addresses and sizes
  // ****************************************
  localparam logic [7:0] ADDR_SELECT = 8'hc7;
  localparam logic [7:0] ADDR_CONFIG = 8'hd4;
  localparam logic [7:0] ADDR_STATUS = 8'hce;
  localparam int         NUM_EP      = 4;
  localparam int         FIFO_DEPTH  = 4;
  localparam logic [7:0] RESET_VALUE = 8'h00;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CFG_ENABLE   = 7;
  localparam int CFG_TOGGLE   = 3;
  localparam int CFG_DIR      = 2;
  localparam int ST_DIR       = 7;
  localparam int ST_STALL     = 5;
  localparam int ST_TX_READY  = 4;
  localparam int ST_STALL_CRC = 3;
  localparam int ST_SETUP     = 2;
  localparam int ST_OUT       = 1;
  localparam int ST_TX_DONE   = 0;

  typedef enum logic [1:0] {
    EP_CONTROL = 2'h0,
    EP_ISO     = 2'h1,
    EP_BULK    = 2'h2,
    EP_INTR    = 2'h3
  } uec_eptype_type;

  typedef enum logic [1:0] {
    PID_DATA0,
    PID_DATA1,
    PID_SETUP,
    PID_NONE
  } uec_pid_type;

  // Packet event from the serial engine
  typedef struct packed {
    logic                    valid;
    logic [1:0]              ep;
    logic                    is_out;
    logic                    is_setup;
    logic                    data1;
    logic                    crc_ok;
    logic                    in_sent;
    logic                    in_acked;
    logic                    handshake;
  } uec_evt_type;

  // Handshake answer to the serial engine
  typedef struct packed {
    logic nak;
    logic stall;
    logic expect_data1;
    logic send_data1;
  } uec_ans_type;

endpackage : uec_pkg

/* uec_top.sv */
// ****************************************
// Event FIFO
// ****************************************
module uec_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rp_r];

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wp_r] <= in_data;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
        wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      if (pop)
        rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : uec_fifo

// ****************************************
// Endpoint configuration and status
// ****************************************
module uec_top (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 resetn,
  input  wire logic                 usb_bus_reset,
  // Special function register port
  input  wire logic [7:0]           sfr_addr,
  input  wire logic                 sfr_wr,
  input  wire logic                 sfr_rd,
  input  wire logic [7:0]           sfr_wdata,
  output logic      [7:0]           sfr_rdata,
  // Packet events from the serial engine
  input  wire uec_pkg::uec_evt_type evt_in,
  output logic                      evt_ready,
  // Answer for the endpoint of the current event, and enable bits of all endpoints
  output uec_pkg::uec_ans_type      ans,
  output logic      [3:0]           ep_enable
);
  localparam int EW = $bits(uec_pkg::uec_evt_type);

  logic [1:0]           endpoint_index_r;
  logic [7:0]           cfg_r  [uec_pkg::NUM_EP];
  logic [7:0]           sta_r  [uec_pkg::NUM_EP];
  logic [3:0]           exp_r;
  logic                 ev_valid;
  logic [EW-1:0]        ev_bits;
  uec_pkg::uec_evt_type ev;
  logic                 ev_take;
  uec_pkg::uec_eptype_type ev_type;
  logic                 cfg_wr;
  logic                 sta_wr;
  logic                 bus_rst;

  // Events queue here so a burst is not lost while firmware runs
  uec_fifo #(
    .WIDTH (EW),
    .DEPTH (uec_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .resetn    (resetn),
    .in_valid  (evt_in.valid),
    .in_ready  (evt_ready),
    .in_data   (evt_in),
    .out_valid (ev_valid),
    .out_ready (1'b1),
    .out_data  (ev_bits)
  );

  assign ev      = uec_pkg::uec_evt_type'(ev_bits);
  assign ev_take = ev_valid;
  assign ev_type = uec_pkg::uec_eptype_type'(cfg_r[ev.ep][1:0]);
  assign cfg_wr  = sfr_wr && (sfr_addr == uec_pkg::ADDR_CONFIG); // R01
  assign sta_wr  = sfr_wr && (sfr_addr == uec_pkg::ADDR_STATUS);
  assign bus_rst = !resetn || usb_bus_reset;

  // ****************************************
  // Register select
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (bus_rst)
      endpoint_index_r <= '0;
    else if (sfr_wr && sfr_addr == uec_pkg::ADDR_SELECT)
      endpoint_index_r <= sfr_wdata[1:0];
  end

  // ****************************************
  // Config registers and toggle
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (bus_rst)
    begin
      for (int i = 0; i < uec_pkg::NUM_EP; i++)
        cfg_r[i] <= uec_pkg::RESET_VALUE; // R15
    end
    else
    begin
      if (ev_take && ev.is_out && !ev.is_setup && !sta_r[ev.ep][uec_pkg::ST_OUT])
        cfg_r[ev.ep][uec_pkg::CFG_TOGGLE] <= ev.data1; // R05
      if (ev_take && ev.is_setup)
        cfg_r[ev.ep][uec_pkg::CFG_TOGGLE] <= 1'b0; // R05
      if (cfg_wr)
      begin
        cfg_r[endpoint_index_r][7:4] <= {sfr_wdata[7], 3'h0}; // R02 R04
        cfg_r[endpoint_index_r][2:0] <= sfr_wdata[2:0]; // R12 R17
      end
    end
  end

  // ****************************************
  // Expected toggle sequence
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (bus_rst)
      exp_r <= '0;
    else
    begin
      if (ev_take && ev.is_setup)
        exp_r[ev.ep] <= 1'b1; // R09
      else if (ev_take && ev.is_out && !sta_r[ev.ep][uec_pkg::ST_OUT]
               && ev.data1 == exp_r[ev.ep])
        exp_r[ev.ep] <= !exp_r[ev.ep]; // R08 R09
      else if (ev_take && ev.in_acked)
        exp_r[ev.ep] <= !exp_r[ev.ep];
      if (cfg_wr)
        exp_r[endpoint_index_r] <= 1'b0; // R07
    end
  end

  // ****************************************
  // Status registers
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (bus_rst)
    begin
      for (int i = 0; i < uec_pkg::NUM_EP; i++)
        sta_r[i] <= uec_pkg::RESET_VALUE;
    end
    else
    begin
      // Firmware write first so that hardware events win over a clear
      if (sta_wr)
        sta_r[endpoint_index_r] <= {sfr_wdata[7], 1'b0, sfr_wdata[5:0]}; // R16
      if (ev_take && ev.is_setup && ev.crc_ok)
        sta_r[ev.ep] <= 8'h04; // R18
      else if (ev_take)
      begin
        if (ev.is_out && ev_type == uec_pkg::EP_ISO)
          sta_r[ev.ep][uec_pkg::ST_STALL_CRC] <= !ev.crc_ok;
        if (ev.is_out && ev.crc_ok && !sta_r[ev.ep][uec_pkg::ST_OUT])
          sta_r[ev.ep][uec_pkg::ST_OUT] <= 1'b1;
        if ((ev_type == uec_pkg::EP_ISO) ? ev.in_sent : ev.in_acked)
        begin
          sta_r[ev.ep][uec_pkg::ST_TX_READY] <= 1'b0; // R20
          sta_r[ev.ep][uec_pkg::ST_TX_DONE]  <= 1'b1;
        end
        if (ev.handshake && sta_r[ev.ep][uec_pkg::ST_STALL] && ev_type != uec_pkg::EP_ISO)
          sta_r[ev.ep][uec_pkg::ST_STALL_CRC] <= 1'b1; // R21
      end
    end
  end

  // ****************************************
  // Answer and read data
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (bus_rst)
      ans <= '0;
    else
    begin
      ans.nak          <= ev_take && ev.is_out && !ev.is_setup
                          && sta_r[ev.ep][uec_pkg::ST_OUT]; // R19
      ans.stall        <= ev_take && sta_r[ev.ep][uec_pkg::ST_STALL]; // R21
      ans.expect_data1 <= exp_r[ev.ep];
      // Control status stage after a read data stage answers DATA1; direction
      // of a control endpoint comes from the status register, not config
      ans.send_data1   <= (ev_type == uec_pkg::EP_CONTROL)
                          ? (exp_r[ev.ep] || !sta_r[ev.ep][uec_pkg::ST_DIR]) // R10 R13
                          : exp_r[ev.ep];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      sfr_rdata <= '0;
    else if (sfr_rd)
    begin
      case (sfr_addr)
        uec_pkg::ADDR_SELECT: sfr_rdata <= {6'h00, endpoint_index_r};
        uec_pkg::ADDR_CONFIG: sfr_rdata <= cfg_r[endpoint_index_r] & 8'h8f; // R04
        uec_pkg::ADDR_STATUS: sfr_rdata <= sta_r[endpoint_index_r];
        default:              sfr_rdata <= 8'h00;
      endcase
    end
  end

  always_comb
  begin
    for (int i = 0; i < uec_pkg::NUM_EP; i++)
      ep_enable[i] = cfg_r[i][uec_pkg::CFG_ENABLE]; // R02
  end

  // ****************************************
  // Checks
  // ****************************************
  chk_cfg_reserved: assert property (@(posedge clk) disable iff (!resetn) // R04
    sfr_rd && sfr_addr == uec_pkg::ADDR_CONFIG |=> sfr_rdata[6:4] == 3'h0)
    else $error("reserved config bits not zero");
  chk_cfg_reset: assert property (@(posedge clk) // R15
    !resetn |=> cfg_r[0] == 8'h00 && exp_r == 4'h0)
    else $error("config not cleared by reset");
  chk_enable_write: assert property (@(posedge clk) disable iff (!resetn) // R02
    cfg_wr && !usb_bus_reset |=> ep_enable[$past(endpoint_index_r)] == $past(sfr_wdata[7]))
    else $error("enable bit not written");
  chk_setup_flags: assert property (@(posedge clk) disable iff (!resetn) // R18
    ev_take && ev.is_setup && ev.crc_ok && !usb_bus_reset |=> sta_r[$past(ev.ep)] == 8'h04)
    else $error("setup did not clear other flags");
  chk_out_nak: assert property (@(posedge clk) disable iff (!resetn) // R19
    ev_take && ev.is_out && !ev.is_setup && sta_r[ev.ep][uec_pkg::ST_OUT]
    && !usb_bus_reset |=> ans.nak)
    else $error("busy OUT not refused");
  chk_toggle_track: assert property (@(posedge clk) disable iff (!resetn) // R05
    ev_take && ev.is_out && !ev.is_setup && !sta_r[ev.ep][uec_pkg::ST_OUT] && !cfg_wr
    && !usb_bus_reset |=> cfg_r[$past(ev.ep)][3] == $past(ev.data1))
    else $error("toggle status wrong");
  chk_config_toggle: assert property (@(posedge clk) disable iff (!resetn) // R07
    cfg_wr && !usb_bus_reset |=> exp_r[$past(endpoint_index_r)] == 1'b0)
    else $error("configure did not reset toggle");
  chk_tx_ready_clear: assert property (@(posedge clk) disable iff (!resetn) // R20
    ev_take && ev.in_acked && ev_type != uec_pkg::EP_ISO && !sta_wr && !ev.is_setup
    && !usb_bus_reset |=> !sta_r[$past(ev.ep)][uec_pkg::ST_TX_READY])
    else $error("transmit ready not cleared");
  chk_setup_toggle: assert property (@(posedge clk) disable iff (!resetn) // R09
    ev_take && ev.is_setup && !cfg_wr && !usb_bus_reset
    |=> !cfg_r[$past(ev.ep)][uec_pkg::CFG_TOGGLE] && exp_r[$past(ev.ep)])
    else $error("setup did not restart toggle");
  chk_stall_answer: assert property (@(posedge clk) disable iff (!resetn) // R21
    ev_take && sta_r[ev.ep][uec_pkg::ST_STALL] && !usb_bus_reset |=> ans.stall)
    else $error("stall request not answered");
  chk_control_status: assert property (@(posedge clk) disable iff (!resetn) // R10
    ev_take && ev_type == uec_pkg::EP_CONTROL && !sta_r[ev.ep][uec_pkg::ST_DIR]
    && !usb_bus_reset |=> ans.send_data1)
    else $error("control status stage not DATA1");
  cov_setup: cover property (@(posedge clk) ev_take && ev.is_setup);
  cov_nak: cover property (@(posedge clk) ans.nak);
  cov_stall: cover property (@(posedge clk) ans.stall);
  cov_full: cover property (@(posedge clk) !evt_ready);
endmodule : uec_top

/* uec_host_model.sv */
// ****************************************
// Serial engine stand-in for the host side
// ****************************************
module uec_host_model (
  // Clock
  input  wire logic            clk,
  // Event link
  output uec_pkg::uec_evt_type evt,
  input  wire logic            evt_ready
);
  timeunit 1ns;
  timeprecision 1ps;

  initial evt = '0;

  // Push once ready, then return while the answer to this event stands
  task automatic send(input logic [1:0] ep, input logic [6:0] f);
    int n;
    n = 0;
    while (evt_ready !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    evt <= {1'b1, ep, f};
    @(posedge clk);
    // Idle fields never keep the old value, so stale data cannot pass
    evt <= {1'b0, ~ep, ~f};
    // The answer lasts one cycle only, so waiting longer would miss it
    @(posedge clk);
    #1;
  endtask : send
endmodule : uec_host_model

/* uec_top_bench.sv */
module uec_top_bench;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Signals
  // ****************************************
  localparam logic [7:0] CF = uec_pkg::ADDR_CONFIG;
  localparam logic [7:0] ST = uec_pkg::ADDR_STATUS;
  // Event fields: out, setup, data1, crc_ok, in_sent, in_acked, handshake
  localparam logic [6:0] OUT0 = 7'h48;
  localparam logic [6:0] OUT1 = 7'h58;
  localparam logic [6:0] SETUP = 7'h28;
  localparam logic [6:0] HS = 7'h01;
  localparam logic [6:0] ACKIN = 7'h07;
  localparam logic [6:0] ISOIN = 7'h04;
  localparam logic [6:0] ISOBAD = 7'h40;
  logic                 clk;
  logic                 resetn        = 1'b0;
  logic                 usb_bus_reset = 1'b0;
  logic [7:0]           sfr_addr      = 8'h00;
  logic                 sfr_wr        = 1'b0;
  logic                 sfr_rd        = 1'b0;
  logic [7:0]           sfr_wdata     = 8'h00;
  logic [7:0]           sfr_rdata;
  uec_pkg::uec_evt_type evt_in;
  logic                 evt_ready;
  uec_pkg::uec_ans_type ans;
  logic [3:0]           ep_enable;
  int                   n_errors      = 0;
  int                   total_checks  = 0;
  int                   cycles        = 0;

  uec_top i_uec_top (
    .clk           (clk),
    .resetn        (resetn),
    .usb_bus_reset (usb_bus_reset),
    .sfr_addr      (sfr_addr),
    .sfr_wr        (sfr_wr),
    .sfr_rd        (sfr_rd),
    .sfr_wdata     (sfr_wdata),
    .sfr_rdata     (sfr_rdata),
    .evt_in        (evt_in),
    .evt_ready     (evt_ready),
    .ans           (ans),
    .ep_enable     (ep_enable)
  );

  uec_host_model i_uec_host_model (
    .clk       (clk),
    .evt       (evt_in),
    .evt_ready (evt_ready)
  );

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic finish_test;
    if (n_errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    @(posedge clk);
    #1;
    chk(nm, exp, sfr_rdata);
  endtask : rd

  // A hang is cut short well past the expected run length
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_errors++;
      finish_test();
    end
  end

  // ****************************************
  // Sequence
  // ****************************************
  initial
  begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd(CF, 8'h00, "config reset");
    rd(ST, 8'h00, "status reset");
    wr(uec_pkg::ADDR_SELECT, 8'h00);
    wr(CF, 8'hfc);
    rd(CF, 8'h84, "config ep0");
    chk("enable ep0", 8'h01, {4'h0, ep_enable});
    wr(uec_pkg::ADDR_SELECT, 8'h01);
    wr(CF, 8'h86);
    wr(uec_pkg::ADDR_SELECT, 8'h02);
    wr(CF, 8'h82);
    wr(uec_pkg::ADDR_SELECT, 8'h03);
    wr(CF, 8'h85);
    chk("enable all", 8'h0f, {4'h0, ep_enable});
    wr(uec_pkg::ADDR_SELECT, 8'h01);
    rd(CF, 8'h86, "config ep1");
    wr(uec_pkg::ADDR_SELECT, 8'h02);
    i_uec_host_model.send(2'h2, OUT0);
    chk("expect data0", 8'h00, {7'h00, ans.expect_data1});
    rd(CF, 8'h82, "toggle data0");
    rd(ST, 8'h02, "out flag");
    i_uec_host_model.send(2'h2, OUT1);
    chk("nak busy", 8'h01, {7'h00, ans.nak});
    rd(CF, 8'h82, "toggle on nak");
    wr(ST, 8'h00);
    i_uec_host_model.send(2'h2, OUT1);
    chk("no nak", 8'h00, {7'h00, ans.nak});
    chk("expect data1", 8'h01, {7'h00, ans.expect_data1});
    rd(CF, 8'h8a, "toggle data1");
    wr(uec_pkg::ADDR_SELECT, 8'h00);
    wr(ST, 8'h20);
    i_uec_host_model.send(2'h0, HS);
    chk("stall answer", 8'h01, {7'h00, ans.stall});
    rd(ST, 8'h28, "stall sent");
    wr(ST, 8'h30);
    i_uec_host_model.send(2'h0, OUT1);
    rd(CF, 8'h8c, "control toggle");
    i_uec_host_model.send(2'h0, SETUP);
    rd(ST, 8'h04, "setup status");
    rd(CF, 8'h84, "setup toggle");
    i_uec_host_model.send(2'h0, HS);
    chk("stall cleared", 8'h00, {7'h00, ans.stall});
    chk("setup expect", 8'h01, {7'h00, ans.expect_data1});
    chk("status data1", 8'h01, {7'h00, ans.send_data1});
    wr(uec_pkg::ADDR_SELECT, 8'h01);
    wr(ST, 8'h10);
    i_uec_host_model.send(2'h1, ACKIN);
    rd(ST, 8'h01, "bulk in done");
    wr(uec_pkg::ADDR_SELECT, 8'h03);
    wr(ST, 8'h10);
    i_uec_host_model.send(2'h3, ISOIN);
    rd(ST, 8'h01, "iso in done");
    i_uec_host_model.send(2'h3, ISOBAD);
    rd(ST, 8'h09, "iso crc error");
    usb_bus_reset <= 1'b1;
    @(posedge clk);
    usb_bus_reset <= 1'b0;
    @(posedge clk);
    chk("enable bus reset", 8'h00, {4'h0, ep_enable});
    rd(CF, 8'h00, "config bus reset");
    rd(ST, 8'h00, "status bus reset");
    rd(uec_pkg::ADDR_SELECT, 8'h00, "select bus reset");
    finish_test();
  end
endmodule : uec_top_bench
